// >>> verilog/crs_pkg.sv
/*
  Shared constants and types of the common register synchronizer: the
  register map of the bus-interface side, field positions, reset values,
  the handshake length and the carrier of core-side writes.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package crs_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned CRS_ADDR_W = 8;
  localparam int unsigned CRS_DATA_W = 32;
  localparam int unsigned CRS_BE_W = 4;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] CRS_OFF_STATUS = 8'h00;
  localparam logic [7:0] CRS_OFF_FETCH_CTRL = 8'h04;
  localparam logic [7:0] CRS_OFF_FETCHED = 8'h08;
  localparam logic [7:0] CRS_OFF_CORE_BASE = 8'h40;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int unsigned CRS_ST_BUSY_BIT = 0;
  localparam int unsigned CRS_ST_REPEAT_BIT = 1;
  localparam int unsigned CRS_FC_ADDR_LSB = 0;
  localparam int unsigned CRS_FC_ADDR_W = 8;
  localparam int unsigned CRS_FC_REPEAT_BIT = 14;
  localparam int unsigned CRS_FC_TRIGGER_BIT = 15;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] CRS_RST_WORD = 32'h0000_0000;
  localparam logic [7:0] CRS_RST_FETCH_ADDR = 8'h00;

  // ************************************************************
  // handshake timing: core clock rising edges seen per crossing
  // ************************************************************
  localparam logic [3:0] CRS_SYNC_CORE_EDGES = 4'h6;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } crs_core_wr_t;

  typedef enum logic [3:0] {
    CRS_K_WR = 4'h1,
    CRS_K_FETCH = 4'h2,
    CRS_K_RD = 4'h4,
    CRS_K_REPEAT = 4'h8
  } crs_kind_t;

  typedef enum logic [2:0] {
    CRS_B_IDLE = 3'h1,
    CRS_B_RESP = 3'h2,
    CRS_B_RDSYNC = 3'h4
  } crs_bus_st_t;

endpackage

// >>> verilog/crs_clk_edge.sv
/*
  Samples the core domain clock as a plain input and reports each of its
  rising edges as a one-cycle pulse on the bus clock.
  Assumes the core clock runs at no more than a third of the bus clock.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_clk_edge (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic core_domain_clock,
  output logic rise
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
    logic rise;
  } crs_edge_st_t;

  crs_edge_st_t s_q;
  crs_edge_st_t s_d;

  // the first stage feeds only the second; the level moves once the
  // second and third stages agree, which filters a metastable sample
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[1:0], core_domain_clock};
    s_d.rise = 1'b0;
    if (s_q.stage[1] == s_q.stage[2] && s_q.stage[2] != s_q.level) begin
      s_d.level = s_q.stage[2];
      s_d.rise = s_q.stage[2];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.rise;

endmodule

`default_nettype wire

// >>> verilog/crs_common_sync.sv
/*
  Common register synchronizer: one shared crossing engine between the
  Avalon-MM bus interface and a peripheral core on its own clock, with a
  sync-in-progress flag, bus stalls on conflicting accesses and a value
  fetch (one-shot or repeating) for read-synchronized core registers.
  Assumes the core logic takes core_wr pulses as its register writes and
  drives core_rd_data combinationally from core_rd_addr.
  The core clock must run at no more than a third of the bus clock.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// - bus-side registers answer at once, except a fetch control write while busy, and a core register write is answered as its crossing starts.
// - flagged core registers are fetched across on read, others are read from the copy.
// - the full crossing handshake always runs, whatever the core clock's source.
// - one shared engine serves every core register, one crossing at a time.
// - a core write starts a crossing that raises the busy flag until it completes.
// - a further core write while busy is stalled until the crossing finishes.
// - a read of the register being written is stalled until its crossing completes.
// - a plain core register holds its synced value and is read while busy without stall.
// - bus-side registers are read without stall while a crossing runs.
// - a flagged core read stalls at once for its own crossing and leaves busy clear.
// - a flagged core read while busy waits for that crossing and then for its own.
// - the fetch control register gives a stall-free way to read flagged values.
// - the trigger bit fetches the addressed register, sets busy, and holds the value.
// - the repeat bit refetches without busy after the first pass until a core write.
// - each crossing lasts over five core periods plus two bus periods, under six plus three.
module crs_common_sync #(
  parameter int unsigned NCORE = 16,
  parameter logic [15:0] RDSYNC_MASK = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic core_domain_clock,
  input wire logic [crs_pkg::CRS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [crs_pkg::CRS_DATA_W-1:0] avs_writedata,
  input wire logic [crs_pkg::CRS_BE_W-1:0] avs_byteenable,
  output logic [crs_pkg::CRS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output crs_pkg::crs_core_wr_t core_wr,
  output logic [7:0] core_rd_addr,
  input wire logic [31:0] core_rd_data,
  output logic sync_in_progress_flag
);

  // index width of the core copy; one bit even for a single register
  localparam int unsigned IDX_W = (NCORE > 1) ? $clog2(NCORE) : 1;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    crs_pkg::crs_bus_st_t bst;
    logic wait_n;
    logic stall;
    logic [31:0] rdata;
    logic act;
    crs_pkg::crs_kind_t kind;
    logic [3:0] cnt;
    logic busy;
    logic [IDX_W-1:0] wr_idx;
    logic [31:0] wr_data;
    crs_pkg::crs_core_wr_t cw;
    logic [7:0] rd_addr;
    logic [7:0] fetch_addr;
    logic repeat_on;
    logic [31:0] fetched;
    // core copy of every register; read-synchronized ones are fetched instead
    logic [NCORE-1:0][31:0] shadow;
  } crs_state_t;

  crs_state_t s_q;
  crs_state_t s_d;
  logic core_rise;

  crs_clk_edge u_edge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .core_domain_clock(core_domain_clock),
    .rise(core_rise)
  );

  // lanes left out keep the core copy, so a partial write still crosses a whole word
  function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // address decode
  // ************************************************************
  logic [7:0] core_off;
  logic in_core;
  logic [IDX_W-1:0] idx;
  logic rd_synced;
  logic engine_free;
  logic done;

  always_comb begin
    core_off = avs_address - crs_pkg::CRS_OFF_CORE_BASE;
    // words past the last core register decode as bus-side and read as unmapped
    in_core = (avs_address >= crs_pkg::CRS_OFF_CORE_BASE) &&
              ({2'b00, core_off[7:2]} < 8'(NCORE));
    idx = IDX_W'(core_off[7:2]);
    rd_synced = in_core && RDSYNC_MASK[idx];
    // a repeating fetch pass after the first gives way to any new crossing
    // an overtaken pass loses its capture; passes resume once the engine is free, unless a core write overtook it
    engine_free = !s_q.act || (s_q.kind == crs_pkg::CRS_K_REPEAT && !s_q.busy);
    // the handshake always counts real core edges
    // it ends one bus cycle after the sixth edge: the first edge seen may have
    // happened just before the start, and the spare cycle keeps the shortest
    // crossing above five core periods plus two bus periods
    done = s_q.act && (s_q.cnt == crs_pkg::CRS_SYNC_CORE_EDGES);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.cw.valid = 1'b0;

    // crossing engine
    if (s_q.act && core_rise && !done) begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
    if (done) begin
      s_d.act = 1'b0;
      s_d.busy = 1'b0;
      case (s_q.kind)
        crs_pkg::CRS_K_WR: begin
          s_d.cw.valid = 1'b1;
          s_d.cw.addr = s_q.rd_addr;
          s_d.cw.data = s_q.wr_data;
          s_d.shadow[s_q.wr_idx] = s_q.wr_data;
        end
        crs_pkg::CRS_K_FETCH, crs_pkg::CRS_K_REPEAT: begin
          s_d.fetched = core_rd_data;
        end
        default: begin
        end
      endcase
    end
    // later passes of a repeating fetch leave the flag clear
    if (!s_d.act && s_q.repeat_on) begin
      s_d.act = 1'b1;
      s_d.cnt = 4'h0;
      s_d.kind = crs_pkg::CRS_K_REPEAT;
      s_d.rd_addr = s_q.fetch_addr;
    end

    // bus interface
    case (s_q.bst)
      crs_pkg::CRS_B_IDLE: begin
        if (avs_write) begin
          if (in_core) begin
            // no accept while the flag is up
            if (engine_free && !s_q.busy) begin
              s_d.act = 1'b1;
              s_d.cnt = 4'h0;
              s_d.kind = crs_pkg::CRS_K_WR;
              s_d.busy = 1'b1;
              s_d.wr_idx = idx;
              s_d.rd_addr = avs_address;
              s_d.wr_data = merge_be(s_q.shadow[idx], avs_writedata, avs_byteenable);
              // a write crossing stops any repeating fetch for good
              s_d.repeat_on = 1'b0;
              s_d.wait_n = 1'b1;
              s_d.bst = crs_pkg::CRS_B_RESP;
            end
          end else if (avs_address == crs_pkg::CRS_OFF_FETCH_CTRL) begin
            // the fetch control waits out a flagged crossing
            if (!s_q.busy) begin
              if (avs_byteenable[0]) begin
                s_d.fetch_addr = avs_writedata[crs_pkg::CRS_FC_ADDR_LSB +: 8];
              end
              if (avs_byteenable[1]) begin
                s_d.repeat_on = avs_writedata[crs_pkg::CRS_FC_REPEAT_BIT];
                if (avs_writedata[crs_pkg::CRS_FC_TRIGGER_BIT]) begin
                  s_d.act = 1'b1;
                  s_d.cnt = 4'h0;
                  s_d.busy = 1'b1;
                  s_d.kind = avs_writedata[crs_pkg::CRS_FC_REPEAT_BIT] ?
                             crs_pkg::CRS_K_REPEAT : crs_pkg::CRS_K_FETCH;
                  s_d.rd_addr = avs_byteenable[0] ?
                                avs_writedata[crs_pkg::CRS_FC_ADDR_LSB +: 8] :
                                s_q.fetch_addr;
                end
              end
              s_d.wait_n = 1'b1;
              s_d.bst = crs_pkg::CRS_B_RESP;
            end
          end else begin
            // read-only and unmapped words take the write and drop it
            s_d.wait_n = 1'b1;
            s_d.bst = crs_pkg::CRS_B_RESP;
          end
        end else if (avs_read) begin
          if (rd_synced) begin
            // first wait out the flagged crossing
            if (!s_q.busy && engine_free) begin
              s_d.act = 1'b1;
              s_d.cnt = 4'h0;
              s_d.kind = crs_pkg::CRS_K_RD;
              s_d.rd_addr = avs_address;
              s_d.bst = crs_pkg::CRS_B_RDSYNC;
            end
          end else if (in_core) begin
            if (!(s_q.busy && s_q.kind == crs_pkg::CRS_K_WR && s_q.wr_idx == idx)) begin
              s_d.rdata = s_q.shadow[idx];
              s_d.wait_n = 1'b1;
              s_d.bst = crs_pkg::CRS_B_RESP;
            end
          end else begin
            case (avs_address)
              crs_pkg::CRS_OFF_STATUS: begin
                s_d.rdata = crs_pkg::CRS_RST_WORD;
                s_d.rdata[crs_pkg::CRS_ST_BUSY_BIT] = s_q.busy;
                s_d.rdata[crs_pkg::CRS_ST_REPEAT_BIT] = s_q.repeat_on;
              end
              crs_pkg::CRS_OFF_FETCH_CTRL: begin
                s_d.rdata = crs_pkg::CRS_RST_WORD;
                s_d.rdata[crs_pkg::CRS_FC_ADDR_LSB +: 8] = s_q.fetch_addr;
                s_d.rdata[crs_pkg::CRS_FC_REPEAT_BIT] = s_q.repeat_on;
              end
              crs_pkg::CRS_OFF_FETCHED: s_d.rdata = s_q.fetched;
              default: s_d.rdata = crs_pkg::CRS_RST_WORD;
            endcase
            s_d.wait_n = 1'b1;
            s_d.bst = crs_pkg::CRS_B_RESP;
          end
        end
      end
      crs_pkg::CRS_B_RDSYNC: begin
        // the stall ends with the engine's completion
        // core_rd_addr stood still through the crossing, so the value is settled
        if (done) begin
          s_d.rdata = core_rd_data;
          s_d.wait_n = 1'b1;
          s_d.bst = crs_pkg::CRS_B_RESP;
        end
      end
      crs_pkg::CRS_B_RESP: begin
        // one cycle of waitrequest low, then back to stalling
        s_d.wait_n = 1'b0;
        s_d.bst = crs_pkg::CRS_B_IDLE;
      end
      default: begin
        s_d.wait_n = 1'b0;
        s_d.bst = crs_pkg::CRS_B_IDLE;
      end
    endcase
    // waitrequest has its own flop so that the pin carries no inverter
    s_d.stall = !s_d.wait_n;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.bst <= crs_pkg::CRS_B_IDLE;
      // waitrequest rests high: a request in the first cycles simply waits
      s_q.stall <= 1'b1;
      s_q.kind <= crs_pkg::CRS_K_WR;
      s_q.fetch_addr <= crs_pkg::CRS_RST_FETCH_ADDR;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs, all straight from state
  // ************************************************************
  // waitrequest is high whenever no answer is being presented
  assign avs_waitrequest = s_q.stall;
  assign avs_readdata = s_q.rdata;
  assign core_wr = s_q.cw;
  assign core_rd_addr = s_q.rd_addr;
  assign sync_in_progress_flag = s_q.busy;

endmodule

`default_nettype wire

// >>> tb/crs_sync_monitor.sv
/*
  Port checker of the common register synchronizer.
  Assumes the bench runs the core clock at five bus periods.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_sync_monitor #(
  parameter int unsigned NCORE = 16,
  parameter logic [15:0] RDSYNC_MASK = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [crs_pkg::CRS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire crs_pkg::crs_core_wr_t core_wr,
  input wire logic sync_in_progress_flag
);
  // ************************************************************
  // busy run length, in bus cycles
  // ************************************************************
  // one cycle of slack on top: the flag count includes the clearing edge
  localparam int LO = 27;
  localparam int HI = 34;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic is_core;
  logic is_sync;
  logic [7:0] idx;

  assign is_core = avs_address >= crs_pkg::CRS_OFF_CORE_BASE;
  assign idx = (avs_address - crs_pkg::CRS_OFF_CORE_BASE) >> 2;
  assign is_sync = is_core && RDSYNC_MASK[idx[3:0]];
  assign run_d = sync_in_progress_flag ? run_q + 8'h01 : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 8'h00;
    end else begin
      run_q <= run_d;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_rdsync_start;
    $rose(avs_read) && is_sync && !sync_in_progress_flag;
  endsequence
  sequence s_quiet_stall;
    (avs_waitrequest && !sync_in_progress_flag) [*8];
  endsequence

  a_ready_one_cycle: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low over one cycle");
  a_idle_waits: assert property (
    !avs_read && !avs_write |-> avs_waitrequest) else $error("ready without request");
  a_write_sets_busy: assert property (
    avs_write && is_core && !avs_waitrequest |-> sync_in_progress_flag)
    else $error("core write taken without busy");
  a_busy_ends_write: assert property (
    core_wr.valid |-> !sync_in_progress_flag && $past(sync_in_progress_flag))
    else $error("core write not at crossing end");
  a_write_stalls: assert property (
    avs_write && is_core && sync_in_progress_flag && $past(sync_in_progress_flag)
    |-> avs_waitrequest) else $error("core write taken while busy");
  a_bus_read_fast: assert property (
    $rose(avs_read) && !is_core |=> !avs_waitrequest) else $error("bus-side read stalled");
  a_rdsync_quiet: assert property (
    s_rdsync_start |=> s_quiet_stall) else $error("synced read not stalled or set busy");
  a_rdsync_len: assert property (
    s_rdsync_start |-> ##[26:38] !avs_waitrequest) else $error("synced read length off");
  a_cross_len: assert property (
    $fell(sync_in_progress_flag) |-> run_q >= LO && run_q <= HI)
    else $error("crossing length out of range");
endmodule

bind crs_common_sync crs_sync_monitor #(.NCORE(NCORE), .RDSYNC_MASK(RDSYNC_MASK)) mon_u (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .core_wr(core_wr),
  .sync_in_progress_flag(sync_in_progress_flag)
);

`default_nettype wire

// >>> tb/crs_core_model.sv
/*
  Behavioural peripheral core: free-running core clock and sixteen
  core registers. Assumes writes arrive as core_wr pulses on the bus clock.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_core_model (
  input wire logic clk_sys,
  output logic core_domain_clock,
  input wire crs_pkg::crs_core_wr_t core_wr,
  input wire logic [7:0] core_rd_addr,
  output logic [31:0] core_rd_data
);
  logic [31:0] regs [16];

  // odd offset keeps the core clock out of phase with the bus clock
  initial begin
    core_domain_clock = 1'b0;
    foreach (regs[i]) regs[i] = 32'h0000_0000;
    #3;
    forever #20 core_domain_clock = ~core_domain_clock;
  end

  always @(posedge clk_sys) begin
    if (core_wr.valid === 1'b1) begin
      regs[core_wr.addr[5:2]] <= core_wr.data;
    end
  end

  // outside the core range the lines carry a pattern, not a stale value
  assign core_rd_data = (core_rd_addr[7:6] == 2'b01) ? regs[core_rd_addr[5:2]]
                        : {4{~core_rd_addr}};

  // the core changes its own status values
  task automatic poke(input int i, input logic [31:0] v);
    regs[i] = v;
  endtask
endmodule

`default_nettype wire

// >>> tb/common_register_sync_tb.sv
/*
  Self-checking bench of the common register synchronizer.
  Assumes core register 1 is read-synchronized, the rest plain.
*/
`timescale 1ns/10ps
`default_nettype none

module common_register_sync_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] av_addr = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  crs_pkg::crs_core_wr_t core_wr;
  logic [7:0] core_rd_addr;
  logic [31:0] core_rd_data;
  logic core_clk;
  logic flag;
  logic [31:0] rdata;
  logic stall;
  int nwait;
  int failures = 0;
  int n_compared = 0;

  always #4 clk_sys = ~clk_sys;

  crs_common_sync #(.NCORE(16), .RDSYNC_MASK(16'h0002)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .core_domain_clock(core_clk),
    .avs_address(av_addr), .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(av_wdata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_wr(core_wr), .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data),
    .sync_in_progress_flag(flag)
  );

  crs_core_model core_u (
    .clk_sys(clk_sys), .core_domain_clock(core_clk), .core_wr(core_wr),
    .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // plain access answers at the second edge; more edges mean a stall
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    av_addr <= a;
    av_rd <= !w;
    av_wr <= w;
    av_wdata <= d;
    nwait = 0;
    do begin
      @(posedge clk_sys);
      nwait++;
    end while (avs_waitrequest !== 1'b0 && nwait < 300);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      complete_run();
    end
    rdata = avs_readdata;
    stall = (nwait > 2);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      xfer(1'b0, crs_pkg::CRS_OFF_STATUS, 32'h0);
      k++;
    end while (rdata[0] !== 1'b0 && k < 100);
    if (k >= 100) begin
      failures++;
      complete_run();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    xfer(1'b0, crs_pkg::CRS_OFF_STATUS, 32'h0);
    chk("status", crs_pkg::CRS_RST_WORD, rdata);
    xfer(1'b0, crs_pkg::CRS_OFF_FETCH_CTRL, 32'h0);
    chk("fetch ctrl", crs_pkg::CRS_RST_WORD, rdata);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rdata);
    $display("reset test done");
  endtask

  task automatic t_write();
    xfer(1'b1, 8'h40, 32'h1111_2222);
    chk("write stall", 32'h0, stall);
    xfer(1'b0, crs_pkg::CRS_OFF_STATUS, 32'h0);
    chk("busy", 32'h1, rdata);
    chk("flag pin", 32'h1, flag);
    xfer(1'b0, 8'h4c, 32'h0);
    chk("plain read", 32'h0, rdata);
    chk("plain stall", 32'h0, stall);
    xfer(1'b1, 8'h48, 32'h3333_4444);
    chk("second write stall", 32'h1, stall);
    xfer(1'b0, 8'h48, 32'h0);
    chk("written reg", 32'h3333_4444, rdata);
    chk("written reg stall", 32'h1, stall);
    wait_idle();
    chk("core reg 0", 32'h1111_2222, core_u.regs[0]);
    chk("core reg 2", 32'h3333_4444, core_u.regs[2]);
    $display("write test done");
  endtask

  task automatic t_rdsync();
    xfer(1'b1, 8'h44, 32'h5555_0001);
    wait_idle();
    core_u.poke(1, 32'h5555_00aa);
    xfer(1'b0, 8'h44, 32'h0);
    chk("synced value", 32'h5555_00aa, rdata);
    chk("synced stall", 32'h1, stall);
    xfer(1'b1, 8'h40, 32'h0000_0007);
    xfer(1'b0, 8'h44, 32'h0);
    chk("double stall", 32'h1, nwait > 50);
    chk("synced after wait", 32'h5555_00aa, rdata);
    $display("read sync test done");
  endtask

  task automatic t_fetch();
    core_u.poke(1, 32'h0000_a5a5);
    xfer(1'b1, crs_pkg::CRS_OFF_FETCH_CTRL, 32'h0000_8044);
    chk("fetch ctrl stall", 32'h0, stall);
    xfer(1'b0, crs_pkg::CRS_OFF_STATUS, 32'h0);
    chk("fetch busy", 32'h1, rdata);
    wait_idle();
    xfer(1'b0, crs_pkg::CRS_OFF_FETCHED, 32'h0);
    chk("fetched", 32'h0000_a5a5, rdata);
    chk("fetched stall", 32'h0, stall);
    xfer(1'b1, crs_pkg::CRS_OFF_FETCH_CTRL, 32'h0000_c044);
    wait_idle();
    core_u.poke(1, 32'h0000_5a5a);
    // several repeat passes fit in this wait
    repeat (100) @(posedge clk_sys);
    xfer(1'b0, crs_pkg::CRS_OFF_STATUS, 32'h0);
    chk("repeat on", 32'h2, rdata);
    xfer(1'b0, crs_pkg::CRS_OFF_FETCHED, 32'h0);
    chk("refetched", 32'h0000_5a5a, rdata);
    xfer(1'b1, 8'h40, 32'h0);
    wait_idle();
    chk("repeat stopped", 32'h0, rdata[1]);
    $display("fetch test done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_write();
    t_rdsync();
    t_fetch();
    complete_run();
  end
endmodule

`default_nettype wire
